//--- camx_regs.svh
// register offsets, status field positions, reset values and limits of the camera config bank
`ifndef CAMX_REGS_SVH
`define CAMX_REGS_SVH

// ----------------------------------------------------------------------
// byte offsets
// ----------------------------------------------------------------------
`define CAMX_ADDR_W            12
`define CAMX_OFS_WIN_H_OFFSET  12'h008
`define CAMX_OFS_WIN_H_SIZE    12'h00c
`define CAMX_OFS_PIX_CLK       12'h404
`define CAMX_OFS_EXP_LOOP      12'h500
`define CAMX_OFS_GAIN_LOOP     12'h504
`define CAMX_OFS_LUM_TYPE      12'h508
`define CAMX_OFS_LUM_TARGET    12'h50c
`define CAMX_OFS_GAIN_LOWER    12'h518
`define CAMX_OFS_GAIN_UPPER    12'h51c
`define CAMX_OFS_CORR_SPEED    12'h520
`define CAMX_OFS_GAIN_STATUS   12'h524
`define CAMX_OFS_FP_ENABLE     12'h700
`define CAMX_OFS_FP_VALUE      12'h704
`define CAMX_OFS_ROW_OVH       12'h708
`define CAMX_OFS_EXP_MODE      12'h720
`define CAMX_OFS_EXP_TIME      12'h728

// ----------------------------------------------------------------------
// field positions in the status word
// ----------------------------------------------------------------------
`define CAMX_STAT_AT_MIN_BIT   28
`define CAMX_STAT_AT_MAX_BIT   29

// ----------------------------------------------------------------------
// limits and reset values
// ----------------------------------------------------------------------
`define CAMX_GAIN_UNITY        14'h0400
`define CAMX_GAIN_TOP          14'h3fff
`define CAMX_LUM_MIN           12'h001
`define CAMX_LUM_RESET         12'h800
`define CAMX_PIX_CLK_MIN       9'h020
`define CAMX_EXP_TIME_MAX      20'hf4240
`define CAMX_WIN_STEP          13'h0008
`define CAMX_FP_RESET          20'h00000
`define CAMX_EXP_TIME_RESET    20'h00000
`define CAMX_WIN_OFS_RESET     12'h000
`define CAMX_WIN_SIZE_RESET    13'h0008

`endif

//--- camx_pkg.sv
// enumerated field codes of the camera config bank
`default_nettype none
package camx_pkg;

    typedef enum logic [1:0] {
        CAMX_EXP_FREE     = 2'b00,
        CAMX_EXP_TRIG_PW  = 2'b01,
        CAMX_EXP_INTERNAL = 2'b10,
        CAMX_EXP_RSVD     = 2'b11
    } camx_exp_mode_type;

    typedef enum logic [1:0] {
        CAMX_LUM_AVERAGE = 2'b00,
        CAMX_LUM_PEAK    = 2'b01,
        CAMX_LUM_RSVD2   = 2'b10,
        CAMX_LUM_RSVD3   = 2'b11
    } camx_lum_type_type;

    typedef enum logic [1:0] {
        CAMX_SPEED_1X = 2'b00,
        CAMX_SPEED_2X = 2'b01,
        CAMX_SPEED_3X = 2'b10,
        CAMX_SPEED_4X = 2'b11
    } camx_speed_type;

endpackage
`default_nettype wire

//--- camx_regs_top.sv
// apb register bank for exposure, gain, frame period, pixel clock and image window
//
// Contract
// - gain loop enable bit 0
// - upper gain limit 14 bits, lower+1..16383
// - lower gain limit 14 bits, 1024..upper-1
// - applied gain clamped to limits while looping
// - luminance target 12 bits, 1..4095
// - luminance type average, peak, others reserved
// - correction speed codes 1x to 4x
// - exposure mode free, trigger width, internal
// - internal exposure 20 bits, up to 1 s
// - internal time applied only in internal mode
// - frame period enable bit 0
// - frame period 20 bits, not below minimum; resets to 0, and only written values are raised to the minimum
// - pixel clock 9 bits, 32 to maximum
// - row overhead cleared adds one microsecond
// - window offset 12 bits, multiple of 8
// - window size 13 bits, multiple of 8
// - exposure loop enable bit 0
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "camx_regs.svh"

module camx_regs_top #(
    parameter int GAIN_W = 14,
    parameter int LUM_W  = 12,
    parameter int TIME_W = 20,
    parameter int PCLK_W = 9
) (
    input  wire logic                 ref_clk,
    input  wire logic                 reset_n,

    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [31:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output var  logic [31:0]          prdata,
    output var  logic                 pready,
    output var  logic                 pslverr,

    // limits reported by the sensor side
    input  wire logic [15:0]          max_h_size,
    input  wire logic [23:0]          min_frame_time,
    input  wire logic [PCLK_W-1:0]    pix_clk_max,

    // gain asked for by the loop engine and by the manual path
    input  wire logic [GAIN_W-1:0]    loop_gain_request,
    input  wire logic [GAIN_W-1:0]    manual_gain,

    // configuration towards the imaging core
    output var  logic                 auto_gain_loop_en,
    output var  logic                 auto_exposure_loop_en,
    output var  logic [GAIN_W-1:0]    applied_gain,
    output var  logic [LUM_W-1:0]     lum_target,
    output var  camx_pkg::camx_lum_type_type lum_type,
    output var  camx_pkg::camx_speed_type    corr_speed,
    output var  camx_pkg::camx_exp_mode_type exp_mode,
    output var  logic [TIME_W-1:0]    exp_time_applied,
    output var  logic                 frame_period_en,
    output var  logic [TIME_W-1:0]    frame_period_us,
    output var  logic [PCLK_W-1:0]    pixel_clock_mhz,
    output var  logic                 line_extra_us,
    output var  logic [11:0]          image_window_h_offset,
    output var  logic [12:0]          image_window_h_size
);

    // ------------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------------
    if (GAIN_W != 14 || LUM_W != 12 || TIME_W != 20 || PCLK_W != 9) begin : g_bad_width
        $error("camx_regs_top: field widths are fixed by the register layout");
    end

    // ------------------------------------------------------------------
    // stored fields
    // ------------------------------------------------------------------
    logic                      gain_loop_q;
    logic                      exp_loop_q;

    logic [GAIN_W-1:0]         gain_lower_q;
    logic [GAIN_W-1:0]         gain_upper_q;
    logic [LUM_W-1:0]          lum_target_q;
    camx_pkg::camx_lum_type_type lum_type_q;
    camx_pkg::camx_speed_type  speed_q;

    camx_pkg::camx_exp_mode_type exp_mode_q;
    logic [TIME_W-1:0]         exp_time_q;
    logic [TIME_W-1:0]         exp_applied_q;

    logic                      fp_en_q;
    logic [TIME_W-1:0]         fp_value_q;
    logic [PCLK_W-1:0]         pix_clk_q;
    logic                      row_ovh_q;

    logic [11:0]               win_ofs_q;
    logic [12:0]               win_size_q;

    logic [GAIN_W-1:0]         applied_gain_q;
    logic [GAIN_W-1:0]         applied_gain_d;
    logic                      at_min_q;
    logic                      at_max_q;

    logic [31:0]               prdata_q;
    logic [31:0]               prdata_d;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire logic [11:0] ofs      = paddr[11:0];
    wire logic        in_page  = (paddr[31:12] == 20'h00000);
    wire logic        setup    = psel & ~penable;
    wire logic        wr       = psel & penable & pwrite;

    wire logic hit_win_ofs  = in_page & (ofs == `CAMX_OFS_WIN_H_OFFSET);
    wire logic hit_win_size = in_page & (ofs == `CAMX_OFS_WIN_H_SIZE);
    wire logic hit_pix_clk  = in_page & (ofs == `CAMX_OFS_PIX_CLK);

    wire logic hit_exp_loop = in_page & (ofs == `CAMX_OFS_EXP_LOOP);
    wire logic hit_gain_loop = in_page & (ofs == `CAMX_OFS_GAIN_LOOP);
    wire logic hit_lum_type = in_page & (ofs == `CAMX_OFS_LUM_TYPE);
    wire logic hit_lum_tgt  = in_page & (ofs == `CAMX_OFS_LUM_TARGET);
    wire logic hit_g_lower  = in_page & (ofs == `CAMX_OFS_GAIN_LOWER);
    wire logic hit_g_upper  = in_page & (ofs == `CAMX_OFS_GAIN_UPPER);
    wire logic hit_speed    = in_page & (ofs == `CAMX_OFS_CORR_SPEED);
    wire logic hit_status   = in_page & (ofs == `CAMX_OFS_GAIN_STATUS);

    wire logic hit_fp_en    = in_page & (ofs == `CAMX_OFS_FP_ENABLE);
    wire logic hit_fp_val   = in_page & (ofs == `CAMX_OFS_FP_VALUE);
    wire logic hit_row_ovh  = in_page & (ofs == `CAMX_OFS_ROW_OVH);
    wire logic hit_exp_mode = in_page & (ofs == `CAMX_OFS_EXP_MODE);
    wire logic hit_exp_time = in_page & (ofs == `CAMX_OFS_EXP_TIME);

    wire logic hit_any = hit_win_ofs | hit_win_size | hit_pix_clk | hit_exp_loop
                       | hit_gain_loop | hit_lum_type | hit_lum_tgt | hit_g_lower
                       | hit_g_upper | hit_speed | hit_status | hit_fp_en
                       | hit_fp_val | hit_row_ovh | hit_exp_mode | hit_exp_time;

    // the status word is read-only; a write to it is flagged like an unmapped one
    wire logic bad_access = ~hit_any | (pwrite & hit_status);

    // ------------------------------------------------------------------
    // write value conditioning: out-of-range values saturate, reserved codes are refused
    // ------------------------------------------------------------------
    // bits above each field are dropped here, so they never store
    wire logic [GAIN_W-1:0] w_gain = pwdata[GAIN_W-1:0];
    wire logic [LUM_W-1:0]  w_lum  = pwdata[LUM_W-1:0];
    wire logic [TIME_W-1:0] w_time = pwdata[TIME_W-1:0];
    wire logic [PCLK_W-1:0] w_pclk = pwdata[PCLK_W-1:0];

    // the lower limit stays at unity or above and strictly below the upper
    wire logic [GAIN_W-1:0] upper_m1 = gain_upper_q - 14'h0001;
    wire logic [GAIN_W-1:0] lower_p1 = gain_lower_q + 14'h0001;

    wire logic [GAIN_W-1:0] new_lower =
        (w_gain < `CAMX_GAIN_UNITY) ? `CAMX_GAIN_UNITY :
        (w_gain > upper_m1)         ? upper_m1         : w_gain;
    // 14 bits already cap the upper limit at the top code
    wire logic [GAIN_W-1:0] new_upper =
        (w_gain < lower_p1) ? lower_p1 : w_gain;

    wire logic [LUM_W-1:0] new_lum =
        (w_lum < `CAMX_LUM_MIN) ? `CAMX_LUM_MIN : w_lum;

    wire logic [TIME_W-1:0] new_exp_time =
        (w_time > `CAMX_EXP_TIME_MAX) ? `CAMX_EXP_TIME_MAX : w_time;

    // a minimum frame time wider than the field saturates to the field top
    wire logic [TIME_W-1:0] fp_floor =
        (min_frame_time[23:TIME_W] != 4'h0) ? {TIME_W{1'b1}} : min_frame_time[TIME_W-1:0];
    wire logic [TIME_W-1:0] new_fp =
        (w_time < fp_floor) ? fp_floor : w_time;

    // the reported maximum wins only over writes above it; a write at or below a maximum under 32 gives 32
    wire logic [PCLK_W-1:0] new_pclk =
        (w_pclk > pix_clk_max)       ? pix_clk_max        :
        (w_pclk < `CAMX_PIX_CLK_MIN) ? `CAMX_PIX_CLK_MIN  : w_pclk;

    // window fields snap down to the 8 pixel grid
    wire logic [12:0] max_h13 =
        (max_h_size[15:13] != 3'h0) ? 13'h1ff8 : {max_h_size[12:3], 3'b000};
    wire logic [12:0] ofs_top  = (max_h13 > `CAMX_WIN_STEP) ? (max_h13 - `CAMX_WIN_STEP) : 13'h0000;
    wire logic [12:0] w_ofs13  = {1'b0, pwdata[11:3], 3'b000};
    wire logic [12:0] ofs_sat  = (w_ofs13 > ofs_top) ? ofs_top : w_ofs13;
    wire logic [11:0] new_win_ofs = ofs_sat[11:0];
    wire logic [12:0] w_size13 = {pwdata[12:3], 3'b000};
    wire logic [12:0] new_win_size =
        (w_size13 < `CAMX_WIN_STEP) ? `CAMX_WIN_STEP :
        (w_size13 > max_h13)        ? max_h13        : w_size13;

    // reserved codes are refused; the old setting stays in force
    wire logic lum_code_ok = (pwdata[1:0] == camx_pkg::CAMX_LUM_AVERAGE)
                           | (pwdata[1:0] == camx_pkg::CAMX_LUM_PEAK);
    wire logic exp_code_ok = (pwdata[1:0] != camx_pkg::CAMX_EXP_RSVD);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_loop_q <= 1'b0;
            exp_loop_q  <= 1'b0;
            fp_en_q     <= 1'b0;
            row_ovh_q   <= 1'b0;
        end else if (wr) begin
            if (hit_gain_loop) gain_loop_q <= pwdata[0];
            if (hit_exp_loop)  exp_loop_q  <= pwdata[0];
            if (hit_fp_en)     fp_en_q     <= pwdata[0];
            if (hit_row_ovh)   row_ovh_q   <= pwdata[0];
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            gain_lower_q <= `CAMX_GAIN_UNITY;
            gain_upper_q <= `CAMX_GAIN_TOP;
            lum_target_q <= `CAMX_LUM_RESET;
        end else if (wr) begin
            if (hit_g_lower) gain_lower_q <= new_lower;
            if (hit_g_upper) gain_upper_q <= new_upper;
            if (hit_lum_tgt) lum_target_q <= new_lum;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            lum_type_q <= camx_pkg::CAMX_LUM_AVERAGE;
            speed_q    <= camx_pkg::CAMX_SPEED_1X;
            exp_mode_q <= camx_pkg::CAMX_EXP_FREE;
        end else if (wr) begin
            if (hit_lum_type && lum_code_ok)
                lum_type_q <= camx_pkg::camx_lum_type_type'(pwdata[1:0]);
            if (hit_speed)
                speed_q <= camx_pkg::camx_speed_type'(pwdata[1:0]);
            if (hit_exp_mode && exp_code_ok)
                exp_mode_q <= camx_pkg::camx_exp_mode_type'(pwdata[1:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            exp_time_q <= `CAMX_EXP_TIME_RESET;
            fp_value_q <= `CAMX_FP_RESET;
            pix_clk_q  <= `CAMX_PIX_CLK_MIN;
        end else if (wr) begin
            if (hit_exp_time) exp_time_q <= new_exp_time;
            if (hit_fp_val)   fp_value_q <= new_fp;
            if (hit_pix_clk)  pix_clk_q  <= new_pclk;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_ofs_q  <= `CAMX_WIN_OFS_RESET;
            win_size_q <= `CAMX_WIN_SIZE_RESET;
        end else if (wr) begin
            if (hit_win_ofs)  win_ofs_q  <= new_win_ofs;
            if (hit_win_size) win_size_q <= new_win_size;
        end
    end

    // holding zero outside internal mode keeps a stale time from leaking in;
    // the flop adds one cycle after a mode or time write
    wire logic [TIME_W-1:0] exp_gate_d =
        (exp_mode_q == camx_pkg::CAMX_EXP_INTERNAL) ? exp_time_q : {TIME_W{1'b0}};

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            exp_applied_q <= `CAMX_EXP_TIME_RESET;
        else
            exp_applied_q <= exp_gate_d;
    end

    // ------------------------------------------------------------------
    // applied gain
    // ------------------------------------------------------------------
    // the loop engine may ask for anything; the limits are enforced here
    // so a misbehaving engine cannot drive the sensor past them
    wire logic req_low  = loop_gain_request < gain_lower_q;
    wire logic req_high = loop_gain_request > gain_upper_q;

    always_comb begin
        if (!gain_loop_q)
            applied_gain_d = manual_gain;
        else if (req_low)
            applied_gain_d = gain_lower_q;
        else if (req_high)
            applied_gain_d = gain_upper_q;
        else
            applied_gain_d = loop_gain_request;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            applied_gain_q <= `CAMX_GAIN_UNITY;
            at_min_q       <= 1'b0;
            at_max_q       <= 1'b0;
        end else begin
            applied_gain_q <= applied_gain_d;
            at_min_q       <= gain_loop_q & req_low;
            at_max_q       <= gain_loop_q & req_high;
        end
    end

    // ------------------------------------------------------------------
    // read mux, sampled in the setup cycle
    // ------------------------------------------------------------------
    always_comb begin
        prdata_d = 32'h00000000;
        if (hit_win_ofs)   prdata_d[11:0]         = win_ofs_q;
        if (hit_win_size)  prdata_d[12:0]         = win_size_q;
        if (hit_pix_clk)   prdata_d[PCLK_W-1:0]   = pix_clk_q;
        if (hit_exp_loop)  prdata_d[0]            = exp_loop_q;
        if (hit_gain_loop) prdata_d[0]            = gain_loop_q;
        if (hit_lum_type)  prdata_d[1:0]          = lum_type_q;
        if (hit_lum_tgt)   prdata_d[LUM_W-1:0]    = lum_target_q;
        if (hit_g_lower)   prdata_d[GAIN_W-1:0]   = gain_lower_q;
        if (hit_g_upper)   prdata_d[GAIN_W-1:0]   = gain_upper_q;
        if (hit_speed)     prdata_d[1:0]          = speed_q;
        if (hit_fp_en)     prdata_d[0]            = fp_en_q;
        if (hit_fp_val)    prdata_d[TIME_W-1:0]   = fp_value_q;
        if (hit_row_ovh)   prdata_d[0]            = row_ovh_q;
        if (hit_exp_mode)  prdata_d[1:0]          = exp_mode_q;
        if (hit_exp_time)  prdata_d[TIME_W-1:0]   = exp_time_q;

        if (hit_status) begin
            prdata_d[GAIN_W-1:0]            = applied_gain_q;
            prdata_d[`CAMX_STAT_AT_MIN_BIT] = at_min_q;
            prdata_d[`CAMX_STAT_AT_MAX_BIT] = at_max_q;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n)
            prdata_q <= 32'h00000000;
        else if (setup && !pwrite)
            prdata_q <= prdata_d;
    end

    // ------------------------------------------------------------------
    // apb answer: zero wait states
    // ------------------------------------------------------------------
    // prdata is captured in setup so the access phase can finish at once
    assign prdata  = prdata_q;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & bad_access;

    // ------------------------------------------------------------------
    // outputs to the core
    // ------------------------------------------------------------------
    assign auto_gain_loop_en     = gain_loop_q;
    assign auto_exposure_loop_en = exp_loop_q;

    assign applied_gain          = applied_gain_q;
    assign lum_target            = lum_target_q;
    assign lum_type              = lum_type_q;
    assign corr_speed            = speed_q;
    assign exp_mode              = exp_mode_q;
    assign exp_time_applied      = exp_applied_q;
    assign frame_period_en       = fp_en_q;
    assign frame_period_us       = fp_value_q;
    assign pixel_clock_mhz       = pix_clk_q;

    // the two-tap restriction is up to software; nothing here enforces it
    assign line_extra_us         = ~row_ovh_q;
    assign image_window_h_offset = win_ofs_q;
    assign image_window_h_size   = win_size_q;

endmodule // camx_regs_top
`default_nettype wire

//--- camx_regs_top_asserts.sv
// concurrent checks on the ports of the camera config register bank
`timescale 1ns/1ps
`default_nettype none
module camx_regs_top_asserts #(
    parameter int GAIN_W = 14,
    parameter int LUM_W  = 12,
    parameter int TIME_W = 20,
    parameter int PCLK_W = 9
) (
    input wire logic                        ref_clk,
    input wire logic                        reset_n,
    input wire logic                        psel,
    input wire logic                        penable,
    input wire logic                        pwrite,
    input wire logic                        pready,
    input wire logic [31:0]                 paddr,
    input wire logic [31:0]                 pwdata,
    input wire logic [PCLK_W-1:0]           pix_clk_max,
    input wire logic                        auto_gain_loop_en,
    input wire logic                        auto_exposure_loop_en,
    input wire logic [GAIN_W-1:0]           applied_gain,
    input wire logic [LUM_W-1:0]            lum_target,
    input var  camx_pkg::camx_lum_type_type lum_type,
    input var  camx_pkg::camx_exp_mode_type exp_mode,
    input wire logic [TIME_W-1:0]           exp_time_applied,
    input wire logic [PCLK_W-1:0]           pixel_clock_mhz,
    input wire logic                        line_extra_us,
    input wire logic [11:0]                 image_window_h_offset,
    input wire logic [12:0]                 image_window_h_size
);
    // ------------------------------------------------------------------
    // write strobe and checks
    // ------------------------------------------------------------------
    wire logic wr_hit = psel && penable && pwrite && pready;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_gain_enable_write: assert property (
        wr_hit && paddr == 32'h504 |=> auto_gain_loop_en == $past(pwdata[0]))
        else $error("gain loop enable differs from written bit");
    a_exposure_enable_write: assert property (
        wr_hit && paddr == 32'h500 |=> auto_exposure_loop_en == $past(pwdata[0]))
        else $error("exposure loop enable differs from written bit");
    // limits are register contents the checker cannot see, so only the floor is tied
    a_gain_floor: assert property (
        $past(auto_gain_loop_en) && auto_gain_loop_en |-> applied_gain >= 14'h0400)
        else $error("applied gain below unity while looping");
    a_exposure_gate: assert property (
        $past(exp_mode) != camx_pkg::CAMX_EXP_INTERNAL |-> exp_time_applied == '0)
        else $error("exposure time applied outside internal mode");
    a_exposure_max: assert property (exp_time_applied <= 20'hf4240)
        else $error("exposure time above one second");
    a_line_extra_write: assert property (
        wr_hit && paddr == 32'h708 |=> line_extra_us == !$past(pwdata[0]))
        else $error("line extra time not inverse of removal bit");
    a_lum_target_min: assert property (lum_target != '0)
        else $error("luminance target is zero");
    a_lum_type_code: assert property (lum_type[1] == 1'b0)
        else $error("luminance type holds a reserved code");
    a_exp_mode_code: assert property (exp_mode != camx_pkg::CAMX_EXP_RSVD)
        else $error("exposure mode holds the reserved code");
    a_pclk_floor: assert property (
        pix_clk_max >= 9'h020 |-> pixel_clock_mhz >= 9'h020)
        else $error("pixel clock below 32");
    a_window_offset_align: assert property (image_window_h_offset[2:0] == 3'h0)
        else $error("window offset not a multiple of 8");
    a_window_size_align: assert property (
        image_window_h_size[2:0] == 3'h0 && image_window_h_size != 13'h0000)
        else $error("window size not a nonzero multiple of 8");
endmodule // camx_regs_top_asserts

bind camx_regs_top camx_regs_top_asserts #(.GAIN_W(GAIN_W), .LUM_W(LUM_W),
    .TIME_W(TIME_W), .PCLK_W(PCLK_W)) u_asserts (.*);
`default_nettype wire

//--- camera_exposure_gain_aoi_regs_bench.sv
// self-checking bench for the camera config register bank
`timescale 1ns/1ps
`default_nettype none
module camera_exposure_gain_aoi_regs_bench;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] e;} camx_step_type;
    logic ref_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
    logic [15:0] max_h_size = 16'h0280;
    logic [23:0] min_frame_time = 24'h000064;
    logic [8:0] pix_clk_max = 9'h0c8, pixel_clock_mhz;
    logic [13:0] loop_gain_request = 14'h0400, manual_gain = 14'h0123, applied_gain;
    logic pready, pslverr, rd_err, auto_gain_loop_en, auto_exposure_loop_en;
    logic frame_period_en, line_extra_us;
    logic [11:0] lum_target, image_window_h_offset;
    logic [12:0] image_window_h_size;
    logic [19:0] exp_time_applied, frame_period_us;
    camx_pkg::camx_lum_type_type lum_type;
    camx_pkg::camx_speed_type corr_speed;
    camx_pkg::camx_exp_mode_type exp_mode;
    int err_total = 0, check_count = 0, cyc = 0;
    // reset contents, then write/readback steps; saturation and reserved codes included
    camx_step_type rst [15] = '{'{12'h504, 0, 0}, '{12'h500, 0, 0}, '{12'h518, 0, 32'h400},
        '{12'h51c, 0, 32'h3fff}, '{12'h50c, 0, 32'h800}, '{12'h508, 0, 0}, '{12'h520, 0, 0},
        '{12'h720, 0, 0}, '{12'h728, 0, 0}, '{12'h700, 0, 0}, '{12'h704, 0, 0},
        '{12'h708, 0, 0}, '{12'h404, 0, 32'h20}, '{12'h008, 0, 0}, '{12'h00c, 0, 32'h8}};
    camx_step_type steps [34] = '{'{12'h504, '1, 1}, '{12'h500, '1, 1},
        '{12'h518, 32'h100, 32'h400}, '{12'h51c, '1, 32'h3fff},
        '{12'h518, 32'hffff1000, 32'h1000}, '{12'h51c, 32'h800, 32'h1001},
        '{12'h51c, 32'h2000, 32'h2000}, '{12'h518, 32'h3000, 32'h1fff},
        '{12'h518, 32'h1000, 32'h1000}, '{12'h50c, 0, 1}, '{12'h50c, '1, 32'hfff},
        '{12'h508, 1, 1}, '{12'h508, 2, 1}, '{12'h508, 0, 0}, '{12'h508, 3, 0},
        '{12'h520, 3, 3}, '{12'h520, 0, 0}, '{12'h520, 1, 1}, '{12'h520, 2, 2},
        '{12'h720, 2, 2}, '{12'h720, 3, 2}, '{12'h720, 1, 1}, '{12'h720, 0, 0},
        '{12'h728, '1, 32'hf4240}, '{12'h700, 1, 1}, '{12'h704, 5, 32'h64},
        '{12'h704, 32'hfff12345, 32'h12345}, '{12'h404, 32'h10, 32'h20},
        '{12'h404, 32'h1ff, 32'hc8}, '{12'h708, 1, 1}, '{12'h008, 32'hfff, 32'h278},
        '{12'h008, 32'h13, 32'h10}, '{12'h00c, 32'h1fff, 32'h280}, '{12'h00c, 3, 8}};
    logic [13:0] greq [3] = '{14'h3000, 14'h0500, 14'h1800};
    logic [13:0] gexp [3] = '{14'h2000, 14'h1000, 14'h1800};
    logic [31:0] sexp [3] = '{32'h20002000, 32'h10001000, 32'h1800};

    camx_regs_top DUT (.*);

    initial forever #2 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------
    // bus and checking tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {20'h00000, a};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1)
            @(posedge ref_clk);
        rd = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge keeps the next request out of this time step
        @(posedge ref_clk);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        chk("applied gain", 32'(applied_gain), 32'h400);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        foreach (rst[i]) begin
            apb(1'b0, rst[i].a, 32'h0);
            chk($sformatf("reset %h", rst[i].a), rd, rst[i].e);
        end
        foreach (steps[i]) begin
            apb(1'b1, steps[i].a, steps[i].d);
            apb(1'b0, steps[i].a, 32'h0);
            chk($sformatf("reg %h", steps[i].a), rd, steps[i].e);
        end
        apb(1'b0, 12'h600, 32'h0);
        chk("unmapped read", rd, 32'h0);
        chk("unmapped error", 32'(rd_err), 32'h1);
        chk("line extra", 32'(line_extra_us), 32'h0);
        chk("frame period enable", 32'(frame_period_en), 32'h1);
        chk("frame period", 32'(frame_period_us), 32'h12345);
        chk("exposure loop", 32'(auto_exposure_loop_en), 32'h1);
        chk("window size", 32'(image_window_h_size), 32'h8);
        chk("speed", 32'(corr_speed), 32'h2);
        apb(1'b1, 12'h708, 32'h0);
        chk("line extra", 32'(line_extra_us), 32'h1);
        apb(1'b1, 12'h728, 32'h1234);
        apb(1'b1, 12'h720, 32'h2);
        @(posedge ref_clk);
        chk("exposure internal", 32'(exp_time_applied), 32'h1234);
        apb(1'b1, 12'h720, 32'h1);
        @(posedge ref_clk);
        chk("exposure trigger", 32'(exp_time_applied), 32'h0);
        foreach (greq[i]) begin
            loop_gain_request <= greq[i];
            repeat (2) @(posedge ref_clk);
            chk("applied gain", 32'(applied_gain), 32'(gexp[i]));
            apb(1'b0, 12'h524, 32'h0);
            chk("gain status", rd, sexp[i]);
        end
        apb(1'b1, 12'h504, 32'h0);
        repeat (2) @(posedge ref_clk);
        chk("manual gain", 32'(applied_gain), 32'h123);
        stop_test();
    end
endmodule // camera_exposure_gain_aoi_regs_bench
`default_nettype wire
